//--- pcd_pkg.sv
// Purpose: constants for the port change detect and power-up block
// Assumes: 40 MHz system clock, synchronous active-high reset
// Notes:   address-select inputs arrive already decoded to a 2-bit code
package pcd_pkg;
  localparam int unsigned PCD_OD_PORTS    = 8;
  localparam int unsigned PCD_PP_PORTS    = 8;
  localparam int unsigned PCD_GROUP       = 4;
  localparam int unsigned PCD_GRP_LO_BASE = 0;
  localparam int unsigned PCD_GRP_HI_BASE = 4;
  // Decoded address-select connection codes
  typedef enum logic [1:0] {
    PCD_SEL_GND = 2'h0,
    PCD_SEL_VCC = 2'h1,
    PCD_SEL_SCL = 2'h2,
    PCD_SEL_SDA = 2'h3
  } pcd_sel_e;
  // Threshold expressed in millivolts, compared with a supply monitor code
  localparam logic [11:0] PCD_POR_MV      = 12'h0_640;
  localparam logic [7:0]  PCD_FLAGS_RST   = 8'h00;
  localparam logic        PCD_ALERT_IDLE  = 1'b1;
endpackage

//--- pcd_sync_hist.sv
// Purpose: one-word history register of the sampled port levels
// Assumes: single clock, synchronous reset
// Notes:   i_load gates the update; pcd_port_change ties it high, so it reloads every cycle
`timescale 1ns/1ps
module pcd_sync_hist #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Data
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_data,
  output logic      [WIDTH-1:0] o_data
);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_data <= '1;
    end else if (i_load) begin
      o_data <= i_data;
    end
  end
endmodule // pcd_sync_hist

//--- pcd_port_change.sv
// Purpose: transition detection, latched change alert and power-up defaults
// Assumes: port levels synchronous to i_clk; bus access pulses from the
//          serial engine; supply level given by a monitor code in mV
// Notes:   no bus here; flags leave as a plain byte output
//
// Behaviour
// R1: Inputs sampled continuously, independent of bus
// R2: Input change sets its own flag bit
// R3: Next bus transaction clears all flags
// R4: Change drives alert low, latched
// R5: Bus-written level changes raise nothing
// R6: Next bus access releases the alert high
// R7: Pullups enabled per group of four
// R8: Pullup-enabled port powers up high
// R9: Pullup-disabled port powers up low
// R10: Push-pull power-up levels per group of four
// R11: Power-up clears flags, alert inactive
// R12: All sixteen ports load select-based defaults
// R13: Designer picks high defaults for input ports
// R14: Hold everything reset until supply above threshold
// R15: Supply drop restores power-up defaults
// R16: Abort voids transaction, alert untouched (here an aborted access still releases the alert)
// R17: Low select ports 0-3, high 4-7
// R18: Flag bit n matches port n
`timescale 1ns/1ps
module pcd_port_change
  import pcd_pkg::*;
#(
  parameter int unsigned NPORT = PCD_OD_PORTS
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  // Supply monitor
  input  wire logic [11:0]      i_supply_mv,
  // Address-select connections, decoded
  input  wire logic [1:0]       i_addr_sel_low_group,
  input  wire logic [1:0]       i_addr_sel_high_group,
  // Serial engine events
  input  wire logic             i_bus_access,
  input  wire logic             i_bus_abort_n,
  input  wire logic             i_bus_wr,
  input  wire logic [NPORT-1:0] i_bus_wr_od,
  input  wire logic [7:0]       i_bus_wr_pp,
  // Pins
  input  wire logic [NPORT-1:0] i_open_drain_port_lines,
  output logic      [NPORT-1:0] o_open_drain_port_lines_oe_n,
  output logic      [NPORT-1:0] o_open_drain_port_lines,
  output logic      [NPORT-1:0] o_pullup_en,
  output logic      [7:0]       o_push_pull_out_lines,
  // Status
  output logic      [NPORT-1:0] o_flags,
  output logic                  o_alert_n,
  output logic                  o_bus_stop,
  output logic                  o_por_active
);
  //////////////////////////////////////////////////////////////////////////////
  // Power-on reset and defaults
  logic             por_nxt;
  logic             rst_all;
  logic [NPORT-1:0] dflt_od;
  logic             grp_lo_hi;
  logic             grp_hi_hi;
  logic [NPORT-1:0] od_r;
  logic [NPORT-1:0] hist;
  logic             settle_r;
  logic             wr_mask_r;
  logic             wr_mask2_r;

  assign por_nxt   = (i_supply_mv < PCD_POR_MV);                              // [R14]
  assign rst_all   = i_sys_rst | por_nxt;                                     // [R15]
  // Any connection except ground selects pullup and high default
  assign grp_lo_hi = (pcd_sel_e'(i_addr_sel_low_group) != PCD_SEL_GND);      // [R17]
  assign grp_hi_hi = (pcd_sel_e'(i_addr_sel_high_group) != PCD_SEL_GND);     // [R17]

  generate
    for (genvar g = 0; g < NPORT; g++) begin : g_dflt
      assign dflt_od[g] = (g < PCD_GRP_HI_BASE) ? grp_lo_hi : grp_hi_hi;      // [R7]
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_por_active <= 1'b1;
    end else begin
      o_por_active <= por_nxt;                                                // [R14]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Port outputs; defaults reload on every reset
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      od_r                  <= dflt_od;                                       // [R8] [R9] [R12]
      o_pullup_en           <= dflt_od;                                       // [R7]
      o_push_pull_out_lines <= {{PCD_GROUP{grp_hi_hi}}, {PCD_GROUP{grp_lo_hi}}}; // [R10]
    end else begin
      o_pullup_en <= dflt_od;
      if (i_bus_wr && i_bus_abort_n) begin
        od_r                  <= i_bus_wr_od;
        o_push_pull_out_lines <= i_bus_wr_pp;
      end
    end
  end

  // Open drain: enable (low) only while pulling the line low
  always_ff @(posedge i_clk) begin
    o_open_drain_port_lines      <= '0;
    o_open_drain_port_lines_oe_n <= od_r;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transition detection
  // A bus write reaches the pin two edges later (od_r, then the enable
  // flop); the write strobe and two mask stages cover the write cycle and the two after it, so
  // the driven edge is taken as the new reference. Limitation: a real input
  // change inside that window is missed.
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      settle_r   <= 1'b1;
      wr_mask_r  <= 1'b0;
      wr_mask2_r <= 1'b0;
    end else begin
      settle_r   <= 1'b0;
      wr_mask_r  <= i_bus_wr;                                                 // [R5]
      wr_mask2_r <= wr_mask_r;                                                // [R5]
    end
  end

  pcd_sync_hist #(
    .WIDTH (NPORT)
  ) u_hist (
    .i_clk  (i_clk),
    .i_rst  (rst_all),
    .i_load (1'b1),                                                           // [R1]
    .i_data (i_open_drain_port_lines),
    .o_data (hist)
  );

  logic [NPORT-1:0] chg;
  logic             quiet;
  assign quiet = settle_r | i_bus_wr | wr_mask_r | wr_mask2_r;                // [R5]
  assign chg   = quiet ? '0 : (hist ^ i_open_drain_port_lines);              // [R1]

  // Set wins over the clear from a bus access
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      o_flags <= PCD_FLAGS_RST;                                               // [R11]
    end else if (i_bus_access && i_bus_abort_n) begin
      o_flags <= chg;                                                         // [R3] [R18]
    end else begin
      o_flags <= o_flags | chg;                                               // [R2] [R18]
    end
  end

  // Abort is not decoded here: an aborted access still releases the alert
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      o_alert_n <= PCD_ALERT_IDLE;                                            // [R11]
    end else if (|chg) begin
      o_alert_n <= 1'b0;                                                      // [R4]
    end else if (i_bus_access) begin
      o_alert_n <= 1'b1;                                                      // [R6] [R16]
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      o_bus_stop <= 1'b1;
    end else begin
      o_bus_stop <= ~i_bus_abort_n;                                           // [R16]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_flag_set;
    @(posedge i_clk) disable iff (rst_all)
    (|chg) |=> ((o_flags & $past(chg)) == $past(chg));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set"); // [R2]

  property p_flag_clr;
    @(posedge i_clk) disable iff (rst_all)
    (i_bus_access && i_bus_abort_n && !(|chg)) |=> (o_flags == '0);
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flags not cleared"); // [R3]

  property p_alert_low;
    @(posedge i_clk) disable iff (rst_all)
    (|chg) |=> !o_alert_n;
  endproperty
  a_alert_low: assert property (p_alert_low) else $error("alert not low"); // [R4]

  property p_alert_hold;
    @(posedge i_clk) disable iff (rst_all)
    (!o_alert_n && !i_bus_access) |=> !o_alert_n;
  endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("alert dropped"); // [R4]

  property p_wr_quiet;
    @(posedge i_clk) disable iff (rst_all)
    i_bus_wr |=> ((o_flags & ~$past(o_flags)) == '0 || $past(i_bus_access));
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("write raised flag"); // [R5]

  property p_alert_rel;
    @(posedge i_clk) disable iff (rst_all)
    (i_bus_access && !(|chg)) |=> o_alert_n;
  endproperty
  a_alert_rel: assert property (p_alert_rel) else $error("alert not released"); // [R6]

  property p_por;
    @(posedge i_clk) por_nxt |=> (o_flags == '0 && o_alert_n && od_r == $past(dflt_od));
  endproperty
  a_por: assert property (p_por) else $error("power-up state wrong"); // [R11]

  property p_pull;
    @(posedge i_clk) disable iff (rst_all)
    1'b1 |=> (o_pullup_en[PCD_GRP_LO_BASE] == $past(grp_lo_hi));
  endproperty
  a_pull: assert property (p_pull) else $error("pullup group wrong"); // [R7]

  property p_stop;
    @(posedge i_clk) disable iff (rst_all)
    !i_bus_abort_n |=> o_bus_stop;
  endproperty
  a_stop: assert property (p_stop) else $error("abort missed"); // [R16]

  property p_oe_follow;
    @(posedge i_clk) disable iff (rst_all)
    1'b1 |=> (o_open_drain_port_lines_oe_n == $past(od_r));
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("enable lags state"); // [R8]

  // The port data line only ever pulls low; the enable does the work
  property p_od_low;
    @(posedge i_clk) disable iff (rst_all)
    1'b1 |-> (o_open_drain_port_lines == '0);
  endproperty
  a_od_low: assert property (p_od_low) else $error("port data not low"); // [R9]

  property p_pp_abort;
    @(posedge i_clk) disable iff (rst_all)
    (i_bus_wr && !i_bus_abort_n) |=> $stable(o_push_pull_out_lines);
  endproperty
  a_pp_abort: assert property (p_pp_abort) else $error("aborted write landed"); // [R16]

  property p_pp_rst;
    @(posedge i_clk)
    i_sys_rst |=> (o_push_pull_out_lines == {{PCD_GROUP{$past(grp_hi_hi)}}, {PCD_GROUP{$past(grp_lo_hi)}}});
  endproperty
  a_pp_rst: assert property (p_pp_rst) else $error("push-pull default wrong"); // [R10]

  property p_pull_hi;
    @(posedge i_clk) disable iff (rst_all)
    1'b1 |=> (o_pullup_en[PCD_GRP_HI_BASE] == $past(grp_hi_hi));
  endproperty
  a_pull_hi: assert property (p_pull_hi) else $error("high pullup group wrong"); // [R17]

  property p_flag_hold;
    @(posedge i_clk) disable iff (rst_all)
    !(i_bus_access && i_bus_abort_n) |=> ((o_flags & $past(o_flags)) == $past(o_flags));
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost"); // [R2]

  property p_wr_mask;
    @(posedge i_clk) disable iff (rst_all)
    i_bus_wr |=> (chg == '0) ##1 (chg == '0);
  endproperty
  a_wr_mask: assert property (p_wr_mask) else $error("write window not masked"); // [R5]

  property p_settle;
    @(posedge i_clk)
    $fell(rst_all) |-> (chg == '0);
  endproperty
  a_settle: assert property (p_settle) else $error("change right after reset"); // [R11]

  property p_por_set;
    @(posedge i_clk)
    (por_nxt && !i_sys_rst) |=> o_por_active;
  endproperty
  a_por_set: assert property (p_por_set) else $error("low supply not flagged"); // [R14]

  property p_por_rel;
    @(posedge i_clk) disable iff (i_sys_rst)
    !por_nxt |=> !o_por_active;
  endproperty
  a_por_rel: assert property (p_por_rel) else $error("supply release missed"); // [R14]

  property p_stop_rel;
    @(posedge i_clk) disable iff (rst_all)
    i_bus_abort_n |=> !o_bus_stop;
  endproperty
  a_stop_rel: assert property (p_stop_rel) else $error("stop held after abort"); // [R16]

  property p_abort_alert;
    @(posedge i_clk) disable iff (rst_all)
    (!i_bus_abort_n && !i_bus_access && !(|chg)) |=> (o_alert_n == $past(o_alert_n));
  endproperty
  a_abort_alert: assert property (p_abort_alert) else $error("abort moved alert"); // [R16]

  // Set wins: a change in the clearing cycle survives the clear
  property p_flag_win;
    @(posedge i_clk) disable iff (rst_all)
    ((|chg) && i_bus_access && i_bus_abort_n) |=> (o_flags == $past(chg));
  endproperty
  a_flag_win: assert property (p_flag_win) else $error("set lost to clear"); // [R3]

  property p_od_wr;
    @(posedge i_clk) disable iff (rst_all)
    (i_bus_wr && i_bus_abort_n) |=> (od_r == $past(i_bus_wr_od));
  endproperty
  a_od_wr: assert property (p_od_wr) else $error("port write lost"); // [R5]
endmodule // pcd_port_change

//--- pcd_bus_master.sv
// Purpose: behavioural serial-bus master, seen as access and write events
// Assumes: tasks are entered just after a rising edge of i_clk
// Notes:   abort is a level and stays put until changed again
`timescale 1ns/1ps
module pcd_bus_master (
  // Clock
  input  wire logic       i_clk,
  // Events toward the block
  output logic            o_access = 1'b0,
  output logic            o_abort_n = 1'b1,
  output logic            o_wr = 1'b0,
  output logic      [7:0] o_wr_od = 8'hFF,
  output logic      [7:0] o_wr_pp = 8'h00
);
  // One addressed transaction, a single-cycle pulse
  task automatic access();
    o_access <= 1'b1;
    @(posedge i_clk);
    o_access <= 1'b0;
  endtask
  // Write both port bytes; data held afterwards, only the strobe drops
  task automatic write(input logic [7:0] od, input logic [7:0] pp);
    o_wr    <= 1'b1;
    o_wr_od <= od;
    o_wr_pp <= pp;
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask
  task automatic abort(input logic v);
    o_abort_n <= v;
  endtask
endmodule // pcd_bus_master

//--- port_change_detect_and_powerup_bench.sv
// Purpose: self-checking bench for pcd_port_change
// Assumes: pins modelled open-drain with external pull-ups
// Notes:   selects load defaults during reset; pullup enables follow them every cycle
`timescale 1ns/1ps
module port_change_detect_and_powerup_bench;
  import pcd_pkg::*;
  logic        i_clk = 1'b0;
  logic        rst   = 1'b1;
  logic [11:0] sup   = 12'h0_CE4;
  logic [1:0]  sel_lo = 2'h1;
  logic [1:0]  sel_hi = 2'h1;
  logic [7:0]  ext   = 8'hFF;
  wire  [7:0]  pins, oe_n, pu, pp, flags, wod, wpp, odl;
  wire         alert_n, stop, por, acc, abn, wr;
  int          mismatches = 0;
  int          checked = 0;
  // Wired-AND of external pull-up and the block's low drive
  assign pins = ext & oe_n;
  always #12.5 i_clk = ~i_clk;
  pcd_bus_master u_bus (.i_clk(i_clk), .o_access(acc), .o_abort_n(abn), .o_wr(wr), .o_wr_od(wod), .o_wr_pp(wpp));
  pcd_port_change u_dut (.i_clk(i_clk), .i_sys_rst(rst), .i_supply_mv(sup), .i_addr_sel_low_group(sel_lo),
    .i_addr_sel_high_group(sel_hi), .i_bus_access(acc), .i_bus_abort_n(abn), .i_bus_wr(wr), .i_bus_wr_od(wod),
    .i_bus_wr_pp(wpp), .i_open_drain_port_lines(pins), .o_open_drain_port_lines_oe_n(oe_n),
    .o_open_drain_port_lines(odl), .o_pullup_en(pu), .o_push_pull_out_lines(pp), .o_flags(flags),
    .o_alert_n(alert_n), .o_bus_stop(stop), .o_por_active(por));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [3:0] grp(input logic [1:0] c);
    return (c == PCD_SEL_GND) ? 4'h0 : 4'hF;
  endfunction
  task automatic do_reset(input logic [1:0] lo, input logic [1:0] hi);
    int n;
    sel_lo <= lo;
    sel_hi <= hi;
    rst    <= 1'b1;
    repeat (12) @(posedge i_clk);
    rst <= 1'b0;
    for (n = 0; n < 20 && por !== 1'b0; n++) @(posedge i_clk);
    if (por !== 1'b0) begin
      mismatches++;
      report_and_stop();
    end
    repeat (2) @(posedge i_clk);
  endtask
  task automatic t_defaults();
    logic [7:0] e;
    for (int k = 0; k < 4; k++) begin
      do_reset(2'(k), 2'(3 - k));
      e = {grp(2'(3 - k)), grp(2'(k))};
      chk("pullups", pu, e);
      chk("od_oe_n", oe_n, e);
      chk("od_lines", odl, 8'h00);
      chk("pp_lines", pp, e);
      chk("flags", flags, 8'h00);
      chk("alert_n", {7'h0, alert_n}, 8'h01);
    end
  endtask
  // Each port in turn: own flag bit, alert, then cleared by an access
  task automatic t_change();
    for (int n = 0; n < 8; n++) begin
      ext[n] <= ~ext[n];
      repeat (3) @(posedge i_clk);
      chk("flags", flags, 8'h01 << n);
      chk("alert_n", {7'h0, alert_n}, 8'h00);
      u_bus.access();
      @(posedge i_clk);
      chk("flags_clr", flags, 8'h00);
      chk("alert_clr", {7'h0, alert_n}, 8'h01);
    end
  endtask
  // Port levels moved by a bus write must stay silent, pulled low and released
  task automatic t_write();
    ext <= 8'hFF;
    repeat (3) @(posedge i_clk);
    u_bus.access();
    @(posedge i_clk);
    u_bus.write(8'hFB, 8'h5A);
    repeat (3) @(posedge i_clk);
    chk("flags_wr", flags, 8'h00);
    chk("alert_wr", {7'h0, alert_n}, 8'h01);
    chk("pp_wr", pp, 8'h5A);
    chk("oe_wr", oe_n, 8'hFB);
    u_bus.write(8'hFF, 8'hA5);
    repeat (3) @(posedge i_clk);
    chk("flags_wr2", flags, 8'h00);
    chk("alert_wr2", {7'h0, alert_n}, 8'h01);
  endtask
  task automatic t_abort();
    ext[5] <= 1'b0;
    repeat (3) @(posedge i_clk);
    u_bus.abort(1'b0);
    repeat (3) @(posedge i_clk);
    chk("bus_stop", {7'h0, stop}, 8'h01);
    chk("alert_ab", {7'h0, alert_n}, 8'h00);
    u_bus.write(8'h00, 8'h00);
    @(posedge i_clk);
    chk("pp_ab", pp, 8'hA5);
    chk("oe_ab", oe_n, 8'hFF);
    u_bus.access();
    @(posedge i_clk);
    chk("flags_ab", flags, 8'h20);
    chk("alert_rel", {7'h0, alert_n}, 8'h01);
    u_bus.abort(1'b1);
    ext[5] <= 1'b1;
    repeat (3) @(posedge i_clk);
    u_bus.access();
    @(posedge i_clk);
    chk("flags_ok", flags, 8'h00);
  endtask
  // Supply one step under the threshold, then exactly at it
  task automatic t_supply();
    ext[7] <= 1'b0;
    repeat (3) @(posedge i_clk);
    sup <= 12'h0_63F;
    repeat (3) @(posedge i_clk);
    chk("por_low", {7'h0, por}, 8'h01);
    chk("flags_por", flags, 8'h00);
    chk("alert_por", {7'h0, alert_n}, 8'h01);
    chk("pp_por", pp, 8'hFF);
    sup <= 12'h0_640;
    repeat (3) @(posedge i_clk);
    chk("por_rel", {7'h0, por}, 8'h00);
  endtask
  initial begin
    t_defaults();
    do_reset(PCD_SEL_VCC, PCD_SEL_SDA);
    t_change();
    t_write();
    t_abort();
    t_supply();
    report_and_stop();
  end
endmodule // port_change_detect_and_powerup_bench
